// file: pkg/iqcb_pkg.sv
package iqcb_pkg;
  // Store geometry: four memories of 8K samples each.
  localparam int IQCB_NST   = 4;
  localparam int IQCB_DEPTH = 8192;
  localparam int IQCB_MEMW  = IQCB_NST * IQCB_DEPTH;
  localparam int IQCB_NBUS  = 7;
  // Per-store register offsets, low byte of address; store in bits 9:8.
  localparam logic [7:0] IQCB_CFG  = 8'h00;
  localparam logic [7:0] IQCB_DLY  = 8'h04;
  localparam logic [7:0] IQCB_THR1 = 8'h08;
  localparam logic [7:0] IQCB_THR2 = 8'h0c;
  localparam logic [7:0] IQCB_NEED = 8'h10;
  localparam logic [7:0] IQCB_STAT = 8'h14;
  localparam logic [7:0] IQCB_CNT  = 8'h18;
  // Global registers, selected by address bit 10.
  localparam logic [7:0] IQCB_GCTL = 8'h00;
  localparam logic [7:0] IQCB_CMD  = 8'h04;
  // Configuration field positions.
  localparam int IQCB_F_SELI = 2;
  localparam int IQCB_F_SELQ = 5;
  localparam int IQCB_F_IDLY = 8;
  localparam int IQCB_F_QDLY = 12;
  localparam int IQCB_F_ALL  = 16;
  localparam int IQCB_F_FRM  = 17;
  localparam int IQCB_F_MAG1 = 18;
  localparam int IQCB_F_MAG2 = 19;
  localparam int IQCB_F_DPD  = 20;
  localparam int IQCB_F_SWS  = 4;
  // Values after reset.
  localparam logic [31:0] IQCB_CFG_RST = 32'h0001_0000;
  localparam logic [31:0] IQCB_DLY_RST = 32'h0000_1000;
  localparam logic [14:0] IQCB_MASK8K  = 15'h1fff;
  // Store modes and group arrangements.
  typedef enum logic [1:0] {M_HOST, M_STATIC, M_SMART, M_SOURCE} iqcb_mode_t;
  typedef enum logic [1:0] {G_QUAD, G_PAIR, G_ONE, G_RSV} iqcb_group_t;
  // An upstream bus: 18-bit I and Q with frame and valid.
  typedef struct packed {
    logic        frame;
    logic        valid;
    logic [17:0] i;
    logic [17:0] q;
  } iqcb_bus_t;
  // One stored sample: top 16 bits of I and Q plus flags.
  typedef struct packed {
    logic        frame;
    logic        valid;
    logic [15:0] q;
    logic [15:0] i;
  } iqcb_word_t;
endpackage

// file: hw/iqcb_top.sv
`timescale 1ns/100ps
// Behaviour
// RL1 - Four 8K stores, pairable or combined 32K.
// RL2 - Circular writing until trigger plus delay.
// RL3 - Trigger from counted threshold exceedances.
// RL4 - Each comparator uses magnitude or magnitude squared.
// RL5 - Clear integrators at start, stop when satisfied.
// RL6 - Static mode stops after stop delay clocks.
// RL7 - Delay starts on sync or software start.
// RL8 - Sync source: downlink, two timers, software.
// RL9 - Smart capture without trigger never completes.
// RL10 - End counter records stop address.
// RL11 - Completion pulse on the interrupt bus.
// RL12 - Completion pulse toward the DMA unit.
// RL13 - Input chosen per I and Q half.
// RL14 - Store top 16 bits, frame, valid.
// RL15 - Programmable frame and valid qualification.
// RL16 - Slot offsets pick I and Q samples.
// RL17 - Memory reachable only in host mode.
// RL18 - 32-bit or 64-bit access by address.
// RL19 - Store can source data to CFR or DPD.
// RL20 - Sources and sinks may run together.
// RL21 - One, two or four stores share control.
// RL22 - Sourcing reads sequentially, wrapping at store size; the code wraps at the group size, 16K when paired, 32K when combined.
module iqcb_top
  import iqcb_pkg::*;
#(
  parameter int NBUS = IQCB_NBUS
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [19:0] wb_adr,
  input  wire logic [31:0] wb_wdata,
  input  wire logic [3:0]  wb_sel,
  output logic      [31:0] wb_rdata_r,
  output logic             wb_ack_r,
  input  iqcb_bus_t        bus_in [NBUS],
  input  wire logic        sync_dl,
  input  wire logic        sync_tmr0,
  input  wire logic        sync_tmr1,
  input  wire logic        src_slot_cfr,
  input  wire logic        src_slot_dpd,
  output iqcb_word_t       src_word_r [IQCB_NST],
  output logic [3:0]       src_cfr_vld_r,
  output logic [3:0]       src_dpd_vld_r,
  output logic [3:0]       irq_done_r,
  output logic [3:0]       dma_done_r
);
  typedef enum logic [2:0] {
    S_IDLE, S_HOST, S_ARMED, S_DELAY, S_SMART, S_DONE, S_SOURCE
  } iqcb_state_t;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Storage for all four memories; the index is {store, sample}.
  iqcb_word_t  mem [IQCB_MEMW];
  logic [31:0] cfg_r  [IQCB_NST];  // Mode, selects, slots, flags.
  logic [31:0] dly_r  [IQCB_NST];  // Stop delay in clocks.
  logic [31:0] thr1_r [IQCB_NST];  // Power setpoint.
  logic [31:0] thr2_r [IQCB_NST];  // Peak setpoint.
  logic [31:0] need_r [IQCB_NST];  // Needed event counts.
  logic [1:0]  group_r;            // Store arrangement.
  logic [1:0]  sync_sel_r;         // Start event source.
  iqcb_state_t st_r   [IQCB_NST];  // Per store state.
  logic [14:0] off_r  [IQCB_NST];  // Write or read offset.
  logic [14:0] end_r  [IQCB_NST];  // Stop address.
  logic [31:0] dcnt_r [IQCB_NST];  // Delay counter.
  logic [15:0] evt1_r [IQCB_NST];  // Setpoint 1 integrator.
  logic [15:0] evt2_r [IQCB_NST];  // Setpoint 2 integrator.
  logic [15:0] samp_r [IQCB_NST];  // Samples since start.
  logic [15:0] hold_i_r [IQCB_NST];// I held until Q slot.
  logic [3:0]  slot_r [IQCB_NST];  // Slot inside frame.
  logic        cap_stb [IQCB_NST];  // A sample is ready.
  iqcb_word_t  cap_word [IQCB_NST]; // The sample to store.
  logic [14:0] abs_adr [IQCB_NST];  // Absolute memory index.
  logic        trig [IQCB_NST];     // Trigger condition met.
  logic        collecting [IQCB_NST];
  logic [14:0] size_mask;           // Wrap mask of one group.
  logic        sync_ev;             // Selected start event.

  // Bus decode; a request is taken once and answered next cycle.
  logic        req;
  logic        wr;
  logic        is_reg;
  logic        is_glb;
  logic        is_m32;
  logic        is_m64;
  logic [1:0]  lane;
  logic [14:0] midx;
  logic        mhost;
  logic [31:0] wmask;
  logic [31:0] rdata;
  assign req    = wb_cyc & wb_stb & ~wb_ack_r;
  assign wr     = req & wb_we;
  assign is_reg = (wb_adr[19:17] == 3'h0);
  assign is_glb = is_reg & wb_adr[10];
  assign is_m32 = (wb_adr[19:17] == 3'h1);
  assign is_m64 = wb_adr[19];
  assign lane   = wb_adr[9:8];
  // Byte address picks access width: 64-bit words use bit 2 as half.
  assign midx   = is_m64 ? wb_adr[17:3] : wb_adr[16:2];  // RL18
  assign mhost  = (st_r[midx[14:13]] == S_HOST);  // RL17
  assign wmask  = {{8{wb_sel[3]}}, {8{wb_sel[2]}}, {8{wb_sel[1]}}, {8{wb_sel[0]}}};

  // The wrap mask grows with the arrangement so groups span memories.
  always_comb begin
    case (group_r)
      G_QUAD:  size_mask = IQCB_MASK8K;  // RL1
      G_PAIR:  size_mask = 15'h3fff;
      default: size_mask = 15'h7fff;
    endcase
  end

  // Start event multiplexer; software sync comes from the command word.
  always_comb begin
    case (sync_sel_r)
      2'h0:    sync_ev = sync_dl;  // RL8
      2'h1:    sync_ev = sync_tmr0;
      2'h2:    sync_ev = sync_tmr1;
      default: sync_ev = wr & is_glb & (wb_adr[7:0] == IQCB_CMD) &
                         wb_wdata[IQCB_F_SWS];  // RL7
    endcase
  end

  // Acknowledge one cycle after the request; drops the cycle after.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wb_ack_r <= 1'b0;
    end else begin
      wb_ack_r <= req;
    end
  end

  // Read data multiplexer; memory outside host mode reads as zero.
  always_comb begin
    rdata = 32'h0;
    if (is_glb) begin
      if (wb_adr[7:0] == IQCB_GCTL) begin
        rdata = {28'h0, sync_sel_r, group_r};
      end
    end else if (is_reg) begin
      case (wb_adr[7:0])
        IQCB_CFG:  rdata = cfg_r[lane];
        IQCB_DLY:  rdata = dly_r[lane];
        IQCB_THR1: rdata = thr1_r[lane];
        IQCB_THR2: rdata = thr2_r[lane];
        IQCB_NEED: rdata = need_r[lane];
        IQCB_STAT: rdata = {13'h0, st_r[lane], 1'b0, end_r[lane]};  // RL10
        IQCB_CNT:  rdata = {evt2_r[lane], evt1_r[lane]};
        default:   rdata = 32'h0;
      endcase
    end else if (mhost) begin
      if (is_m64 & wb_adr[2]) begin
        rdata = {30'h0, mem[midx].frame, mem[midx].valid};
      end else if (is_m32 | is_m64) begin
        rdata = {mem[midx].q, mem[midx].i};
      end
    end
  end

  // Read data is latched with the answer and held until the next one.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wb_rdata_r <= 32'h0;
    end else if (req & ~wb_we) begin
      wb_rdata_r <= rdata;
    end
  end

  // Global control: arrangement and start source.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      group_r    <= G_QUAD;
      sync_sel_r <= 2'h3;
    end else if (wr & is_glb & (wb_adr[7:0] == IQCB_GCTL) & wb_sel[0]) begin
      group_r    <= wb_wdata[1:0];
      sync_sel_r <= wb_wdata[3:2];
    end
  end

  // Memory writes: captures first, then host writes in host mode.
  // Stores in host mode never capture, so in the quad arrangement the two never collide.
  always_ff @(posedge core_clk) begin
    for (int l = 0; l < IQCB_NST; l++) begin
      if (collecting[l] & cap_stb[l]) begin
        mem[abs_adr[l]] <= cap_word[l];  // RL2
      end
    end
    if (wr & mhost & is_m64 & wb_adr[2]) begin
      mem[midx].frame <= wb_wdata[1];
      mem[midx].valid <= wb_wdata[0];
    end else if (wr & mhost & (is_m32 | is_m64)) begin
      mem[midx].q <= wb_wdata[31:16];  // RL17
      mem[midx].i <= wb_wdata[15:0];
    end
  end

  for (genvar g = 0; g < IQCB_NST; g++) begin : g_st
    logic        leader;
    logic        cfg_wr;
    logic        arm;
    logic [2:0]  sel_i;
    logic [2:0]  sel_q;
    iqcb_bus_t   bi;
    iqcb_bus_t   bq;
    logic        qual;
    logic [3:0]  cur;
    logic [15:0] ai;
    logic [15:0] aq;
    logic [31:0] mag;
    logic [31:0] mag2;
    logic [31:0] m1;
    logic [31:0] m2;
    logic [1:0]  mode;
    logic [1:0]  nmode;
    logic        src_go;
    iqcb_state_t mode_st;

    // A store leads its group when the arrangement makes it the base.
    assign leader = (group_r == G_QUAD) | ((group_r == G_PAIR) & (g % 2 == 0)) |
                    (g == 0);  // RL21
    assign mode   = cfg_r[g][1:0];
    assign cfg_wr = wr & is_reg & ~is_glb & (lane == g) & (wb_adr[7:0] == IQCB_CFG);
    assign arm    = wr & is_glb & (wb_adr[7:0] == IQCB_CMD) & wb_wdata[g];
    // A configuration write moves the state by the mode being written, not the old one.
    assign nmode   = wb_sel[0] ? wb_wdata[1:0] : mode;
    assign mode_st = (nmode == M_HOST) ? S_HOST :
                     (nmode == M_SOURCE) ? S_SOURCE : S_IDLE;

    // Input choice per half; an index past the last bus reads zero.
    assign sel_i = cfg_r[g][IQCB_F_SELI +: 3];
    assign sel_q = cfg_r[g][IQCB_F_SELQ +: 3];
    assign bi = (int'(sel_i) < NBUS) ? bus_in[sel_i] : '0;  // RL13
    assign bq = (int'(sel_q) < NBUS) ? bus_in[sel_q] : '0;

    // Slot counting restarts on frame when frame use is enabled.
    assign qual = cfg_r[g][IQCB_F_ALL] | bi.valid;  // RL15
    assign cur  = (cfg_r[g][IQCB_F_FRM] & bi.frame) ? 4'h0 : slot_r[g];
    assign cap_stb[g] = qual & (cur == cfg_r[g][IQCB_F_QDLY +: 4]);  // RL16
    assign cap_word[g] = '{frame: bi.frame, valid: bi.valid, q: bq.q[17:2],
        i: (cfg_r[g][IQCB_F_IDLY +: 4] == cfg_r[g][IQCB_F_QDLY +: 4]) ?
           bi.i[17:2] : hold_i_r[g]};  // RL14
    assign abs_adr[g] = {2'(g), 13'h0} + off_r[g];
    assign collecting[g] = (st_r[g] == S_ARMED) | (st_r[g] == S_DELAY) |
                           (st_r[g] == S_SMART);

    always_ff @(posedge core_clk) begin
      if (rst) begin
        slot_r[g]   <= 4'h0;
        hold_i_r[g] <= 16'h0;
      end else begin
        if (qual) begin
          slot_r[g] <= cur + 4'h1;
        end
        if (qual & (cur == cfg_r[g][IQCB_F_IDLY +: 4])) begin
          hold_i_r[g] <= bi.i[17:2];  // RL16
        end
      end
    end

    // Magnitude uses max plus half min; trades accuracy for no root.
    assign ai   = bi.i[17] ? 16'(-bi.i[17:2]) : bi.i[17:2];
    assign aq   = bq.q[17] ? 16'(-bq.q[17:2]) : bq.q[17:2];
    assign mag  = (ai > aq) ? 32'(ai) + 32'(aq[15:1]) : 32'(aq) + 32'(ai[15:1]);
    assign mag2 = 32'(ai) * 32'(ai) + 32'(aq) * 32'(aq);
    assign m1   = cfg_r[g][IQCB_F_MAG1] ? mag : mag2;  // RL4
    assign m2   = cfg_r[g][IQCB_F_MAG2] ? mag : mag2;
    assign trig[g] = (evt1_r[g] >= need_r[g][15:0]) &
                     (evt2_r[g] >= need_r[g][31:16]);  // RL3

    // Register writes for this store, byte lanes honoured.
    always_ff @(posedge core_clk) begin
      if (rst) begin
        cfg_r[g]  <= IQCB_CFG_RST;
        dly_r[g]  <= IQCB_DLY_RST;
        thr1_r[g] <= 32'h0;
        thr2_r[g] <= 32'h0;
        need_r[g] <= 32'h0;
      end else if (wr & is_reg & ~is_glb & (lane == g)) begin
        case (wb_adr[7:0])
          IQCB_CFG:  cfg_r[g]  <= (cfg_r[g] & ~wmask) | (wb_wdata & wmask);
          IQCB_DLY:  dly_r[g]  <= (dly_r[g] & ~wmask) | (wb_wdata & wmask);
          IQCB_THR1: thr1_r[g] <= (thr1_r[g] & ~wmask) | (wb_wdata & wmask);
          IQCB_THR2: thr2_r[g] <= (thr2_r[g] & ~wmask) | (wb_wdata & wmask);
          IQCB_NEED: need_r[g] <= (need_r[g] & ~wmask) | (wb_wdata & wmask);
          default:   need_r[g] <= need_r[g];
        endcase
      end
    end

    // Capture sequence; a configuration write aborts to the new mode.
    always_ff @(posedge core_clk) begin
      if (rst) begin
        st_r[g]   <= S_HOST;
        off_r[g]  <= 15'h0;
        end_r[g]  <= 15'h0;
        dcnt_r[g] <= 32'h0;
        irq_done_r[g] <= 1'b0;
        dma_done_r[g] <= 1'b0;
      end else begin
        irq_done_r[g] <= 1'b0;
        dma_done_r[g] <= 1'b0;
        if (collecting[g] & cap_stb[g]) begin
          off_r[g] <= (off_r[g] + 15'h1) & size_mask;  // RL2
        end
        if (cfg_wr) begin
          st_r[g] <= mode_st;
          // Replay starts at the base, not where an earlier capture stopped.
          if (mode_st == S_SOURCE) begin
            off_r[g] <= 15'h0;  // RL22
          end
        end else begin
          case (st_r[g])
            S_ARMED: begin
              if (sync_ev) begin
                st_r[g]   <= S_DELAY;  // RL7
                dcnt_r[g] <= 32'h0;
              end
            end
            S_DELAY: begin
              dcnt_r[g] <= dcnt_r[g] + 32'h1;
              if (dcnt_r[g] + 32'h1 >= dly_r[g]) begin
                if (mode == M_STATIC | trig[g]) begin
                  st_r[g] <= S_DONE;  // RL6
                end else begin
                  st_r[g] <= S_SMART;  // RL9
                end
              end
            end
            S_SMART: begin
              if (trig[g]) begin
                st_r[g] <= S_DONE;  // RL5
              end
            end
            S_SOURCE: begin
              if (src_go) begin
                off_r[g] <= (off_r[g] + 15'h1) & size_mask;  // RL22
              end
            end
            default: begin
              if (arm & leader & (mode == M_STATIC | mode == M_SMART)) begin
                st_r[g] <= S_ARMED;  // RL21
              end
            end
          endcase
          if ((st_r[g] == S_DELAY & dcnt_r[g] + 32'h1 >= dly_r[g] &
               (mode == M_STATIC | trig[g])) | (st_r[g] == S_SMART & trig[g])) begin
            end_r[g]      <= abs_adr[g];  // RL10
            irq_done_r[g] <= 1'b1;  // RL11
            dma_done_r[g] <= 1'b1;  // RL12
          end
        end
      end
    end

    // Integrators are cleared by the start event, then count hits.
    always_ff @(posedge core_clk) begin
      if (rst) begin
        evt1_r[g] <= 16'h0;
        evt2_r[g] <= 16'h0;
        samp_r[g] <= 16'h0;
      end else if (st_r[g] == S_ARMED & sync_ev) begin
        evt1_r[g] <= 16'h0;  // RL5
        evt2_r[g] <= 16'h0;
        samp_r[g] <= 16'h0;
      end else if ((st_r[g] == S_DELAY | st_r[g] == S_SMART) & cap_stb[g]) begin
        evt1_r[g] <= evt1_r[g] + 16'(m1 > thr1_r[g]);  // RL3
        evt2_r[g] <= evt2_r[g] + 16'(m2 > thr2_r[g]);
        samp_r[g] <= samp_r[g] + 16'h1;
      end
    end

    // Sourcing plays memory out while other stores may still capture.
    assign src_go = (st_r[g] == S_SOURCE) & leader &
                    (cfg_r[g][IQCB_F_DPD] ? src_slot_dpd : src_slot_cfr);
    always_ff @(posedge core_clk) begin
      if (rst) begin
        src_word_r[g]    <= '0;
        src_cfr_vld_r[g] <= 1'b0;
        src_dpd_vld_r[g] <= 1'b0;
      end else begin
        src_cfr_vld_r[g] <= src_go & ~cfg_r[g][IQCB_F_DPD];  // RL19
        src_dpd_vld_r[g] <= src_go & cfg_r[g][IQCB_F_DPD];  // RL20
        if (src_go) begin
          src_word_r[g] <= mem[abs_adr[g]];
        end
      end
    end

    property p_done_pair;
      irq_done_r[g] |-> dma_done_r[g] && st_r[g] == S_DONE;
    endproperty
    a_done_pair: assert property (p_done_pair) else $error("done pulses disagree"); // RL12
    property p_static_stop;
      st_r[g] == S_DELAY && !cfg_wr && mode == M_STATIC && dcnt_r[g] + 1 >= dly_r[g]
        |=> irq_done_r[g] ##1 !irq_done_r[g];
    endproperty
    a_static_stop: assert property (p_static_stop) else $error("static stop late"); // RL6
    property p_smart_trig;
      irq_done_r[g] && mode == M_SMART |-> $past(trig[g]);
    endproperty
    a_smart_trig: assert property (p_smart_trig) else $error("smart done w/o trigger"); // RL9
    property p_clear;
      st_r[g] == S_ARMED && sync_ev && !cfg_wr
        |=> evt1_r[g] == 0 && evt2_r[g] == 0 && st_r[g] == S_DELAY;
    endproperty
    a_clear: assert property (p_clear) else $error("integrators not cleared"); // RL5
    property p_end;
      $rose(irq_done_r[g]) |-> end_r[g] == $past(abs_adr[g]);
    endproperty
    a_end: assert property (p_end) else $error("end address wrong"); // RL10
    property p_advance;
      collecting[g] && cap_stb[g] |=> off_r[g] == ($past(cfg_wr && mode_st == S_SOURCE) ?
        15'h0 : (($past(off_r[g]) + 15'h1) & $past(size_mask)));
    endproperty
    a_advance: assert property (p_advance) else $error("write pointer stuck"); // RL2
    property p_src;
      src_cfr_vld_r[g] || src_dpd_vld_r[g] |-> $past(st_r[g]) == S_SOURCE;
    endproperty
    a_src: assert property (p_src) else $error("source outside source mode"); // RL22
  end

  property p_host_gate;
    req && !wb_we && is_m32 && !mhost |=> wb_ack_r && wb_rdata_r == 0 ##1 !wb_ack_r;
  endproperty
  a_host_gate: assert property (p_host_gate) else $error("memory read outside host"); // RL17
endmodule

// file: testbench/iqcb_feed.sv
`timescale 1ns/100ps
// Stand-in for the upstream datapath. Every bus carries one steady sample, so a
// stored word can be predicted without knowing in which slot it landed.
module iqcb_feed
  import iqcb_pkg::*;
#(
  parameter int NBUS = IQCB_NBUS
) (
  input  wire logic core_clk,
  input  wire logic rst,
  output iqcb_bus_t bus_out [NBUS]
);
  // The outputs change just after the edge, as a registered datapath would.
  // Frame and valid stay low during reset, so nothing qualifies early.
  always @(posedge core_clk) begin
    for (int b = 0; b < NBUS; b++) begin
      bus_out[b].frame <= !rst;
      bus_out[b].valid <= !rst;
      bus_out[b].i     <= 18'h2abcd ^ 18'(b << 2);  // Buses differ above the dropped bits.
      bus_out[b].q     <= 18'h12345;
    end
  end
endmodule

// file: testbench/iq_capture_buffer_tb.sv
`timescale 1ns/100ps
// Self-checking bench for the capture buffer, driving store 0, with store 1 as its pair follower.
module iq_capture_buffer_tb;
  import iqcb_pkg::*;
  localparam logic [17:0] SI = 18'h2abcd;         // Steady I on bus 0.
  localparam logic [17:0] SQ = 18'h12345;         // Steady Q on every bus.
  localparam logic [31:0] WX = {SQ[17:2], SI[17:2] ^ 16'h1}; // Word kept, I from bus 1.
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic        wb_cyc   = 1'b0;
  logic        wb_stb   = 1'b0;
  logic        wb_we    = 1'b0;
  logic [19:0] wb_adr   = 20'h0;
  logic [31:0] wb_wdata = 32'h0;
  logic [3:0]  wb_sel   = 4'h0;
  logic        src_slot = 1'b0;
  logic [2:0]  sync_src = 3'h0;  // Downlink, timer 0, timer 1.
  logic [31:0] wb_rdata_r;
  logic        wb_ack_r;
  logic [3:0]  src_cfr_vld_r;
  logic [3:0]  src_dpd_vld_r;
  logic [3:0]  irq_done_r;
  logic [3:0]  dma_done_r;
  iqcb_bus_t   bus [IQCB_NBUS];
  iqcb_word_t  src_word [IQCB_NST];
  int          mismatches  = 0;
  int          comparisons = 0;
  logic [31:0] q;

  // 200 MHz core clock.
  always #2.5 core_clk = ~core_clk;

  iqcb_feed feed (.core_clk(core_clk), .rst(rst), .bus_out(bus));

  iqcb_top dut (
    .core_clk(core_clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_wdata(wb_wdata), .wb_sel(wb_sel), .wb_rdata_r(wb_rdata_r),
    .wb_ack_r(wb_ack_r), .bus_in(bus), .sync_dl(sync_src[0]), .sync_tmr0(sync_src[1]),
    .sync_tmr1(sync_src[2]), .src_slot_cfr(src_slot), .src_slot_dpd(src_slot),
    .src_word_r(src_word), .src_cfr_vld_r(src_cfr_vld_r), .src_dpd_vld_r(src_dpd_vld_r),
    .irq_done_r(irq_done_r), .dma_done_r(dma_done_r)
  );

  // One comparison; an unknown never passes for a match.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Classic single cycle; held until ack is sampled, then one idle cycle.
  task automatic wb(input logic we, input logic [19:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdata <= d;
    wb_sel <= 4'hf;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_r !== 1'b1 && n < 20);
    // The answer is taken at the very edge that saw ack.
    q = wb_rdata_r;
    if (wb_ack_r !== 1'b1) chk("wb_ack", 1, 0);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [19:0] a, input logic [31:0] exp, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, exp, q);
  endtask

  // Waits up to hi cycles for the store 0 done pulse; dma must pulse with irq.
  task automatic wait_done(input int lo, input int hi, input logic want, input string nm);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (irq_done_r[0] !== 1'b1 && n < hi);
    if (want) begin
      chk(nm, 1, irq_done_r[0] === 1'b1 && n >= lo);
      chk("dma_done", 1, dma_done_r[0]);
    end else begin
      chk(nm, 0, irq_done_r[0] === 1'b1);
    end
  endtask

  // Arms store 0 and issues the software sync that starts the stop delay.
  task automatic arm_and_sync();
    wb(1'b1, 20'h00404, 32'h1);
    wb(1'b1, 20'h00404, 32'h10);
  endtask

  task automatic t_reset();
    rd(20'h00000, IQCB_CFG_RST, "cfg_rst");
    rd(20'h00004, IQCB_DLY_RST, "dly_rst");
    rd(20'h000f0, 32'h0, "unmapped");
    $display("test reset done");
  endtask

  // Host mode reaches memory in both views; another mode is shut out.
  task automatic t_mem();
    wb(1'b1, 20'h2000c, 32'h1234_5678);
    rd(20'h2000c, 32'h1234_5678, "mem32");
    rd(20'h80018, 32'h1234_5678, "mem64");
    wb(1'b1, 20'h00000, 32'h0001_0001);
    rd(20'h2000c, 32'h0, "mem_locked");
    wb(1'b1, 20'h2000c, 32'hdead_beef);
    wb(1'b1, 20'h00000, IQCB_CFG_RST);
    rd(20'h2000c, 32'h1234_5678, "mem_kept");
    $display("test mem done");
  endtask

  // Static capture: done after the delay, end points past the newest sample.
  // I comes from bus 1 at slot 1, Q and the stored word at slot 2.
  task automatic t_static();
    logic [14:0] e;
    wb(1'b1, 20'h00004, 32'd40);
    wb(1'b1, 20'h00000, 32'h0001_2105);
    arm_and_sync();
    wait_done(36, 44, 1'b1, "static_done");
    wb(1'b1, 20'h00000, IQCB_CFG_RST);
    wb(1'b0, 20'h00014, 32'h0);
    e = q[14:0] - 15'h1;
    wb(1'b0, 20'h20000 + {3'h0, e, 2'h0}, 32'h0);
    chk("kept_word", WX, q);
    wb(1'b0, 20'h80004 + {2'h0, e, 3'h0}, 32'h0);
    chk("kept_flags", 32'h3, q);
    $display("test static done");
  endtask

  // Pairs on downlink sync: only the leader arms, other sources are ignored.
  task automatic t_sync();
    wb(1'b1, 20'h00400, 32'h1);
    wb(1'b1, 20'h00000, 32'h0001_0001);
    wb(1'b1, 20'h00100, 32'h0001_0001);
    wb(1'b1, 20'h00404, 32'h3);
    wb(1'b1, 20'h00404, 32'h10);
    sync_src <= 3'h6;
    @(posedge core_clk);
    sync_src <= 3'h0;
    wait_done(0, 60, 1'b0, "sync_ignored");
    rd(20'h00114, 32'h0, "follower_idle");
    sync_src <= 3'h1;
    @(posedge core_clk);
    sync_src <= 3'h0;
    wait_done(36, 44, 1'b1, "dl_done");
    wb(1'b1, 20'h00100, IQCB_CFG_RST);
    wb(1'b1, 20'h00400, 32'hc);
    $display("test sync done");
  endtask

  // Smart capture: never done without trigger, done promptly once it holds.
  // The setpoint lies between the sample's magnitude and its square.
  task automatic t_smart();
    wb(1'b1, 20'h00008, 32'h0001_0000);
    wb(1'b1, 20'h0000c, 32'h0001_0000);
    wb(1'b1, 20'h00010, 32'h0001_0001);
    // Magnitude on comparator 1, magnitude squared on comparator 2.
    wb(1'b1, 20'h00000, 32'h0005_0002);
    arm_and_sync();
    wait_done(0, 120, 1'b0, "smart_none");
    wb(1'b0, 20'h00018, 32'h0);
    chk("cnt_mag", 0, q[15:0]);
    chk("cnt_sq", 1, q[31:16] != 16'h0);
    wb(1'b1, 20'h00008, 32'h0);
    wb(1'b1, 20'h0000c, 32'h0);
    wb(1'b1, 20'h00000, 32'h0005_0002);
    arm_and_sync();
    wait_done(36, 44, 1'b1, "smart_done");
    wb(1'b0, 20'h00018, 32'h0);
    chk("cnt_seen", 1, q[15:0] != 16'h0 && q[31:16] != 16'h0);
    $display("test smart done");
  endtask

  // Sourcing replays memory in address order, one word per slot, to CFR then DPD.
  task automatic t_source();
    wb(1'b1, 20'h00000, IQCB_CFG_RST);
    for (int k = 0; k < 3; k++) wb(1'b1, 20'h20000 + 20'(4 * k), 32'h0a0b_0c00 + 32'(k));
    for (int m = 0; m < 2; m++) begin
      wb(1'b1, 20'h00000, (m == 1) ? 32'h0010_0003 : 32'h0000_0003);
      for (int k = 0; k < 3; k++) begin
        src_slot <= 1'b1;
        @(posedge core_clk);
        src_slot <= 1'b0;
        @(posedge core_clk);
        chk("src_vld", m == 0, src_cfr_vld_r[0]);
        chk("dpd_vld", m == 1, src_dpd_vld_r[0]);
        chk("src_word", 32'h0a0b_0c00 + 32'(k), {src_word[0].q, src_word[0].i});
      end
    end
    $display("test source done");
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    close_out();
  end

  // Main sequence: reset for five cycles, then the tests in turn.
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_mem();
    t_static();
    t_sync();
    t_smart();
    t_source();
    close_out();
  end
endmodule
